// ===== verilog/mccdo_core.sv
`timescale 1ns/1ps
module mccdo_core #(
  parameter int WDOG_W  = 8,  // Watchdog counter width
  parameter int PRESC_W = 3   // Shared prescaler width
) (
  input  wire logic                 MCLK,
  input  wire logic                 RST_N,
  input  wire logic                 WB_CYC_I,
  input  wire logic                 WB_STB_I,
  input  wire logic                 WB_WE_I,
  input  wire logic [9:0]           WB_ADR_I,
  input  wire logic [3:0]           WB_SEL_I,
  input  wire logic [31:0]          WB_DAT_I,
  output logic      [31:0]          WB_DAT_O,
  output logic                      WB_ACK_O,
  output logic                      GIE_OUT,
  output logic                      NOP_SLOT
);
  import mccdo_pkg::*;

  // Storage
  logic [7:0]         file_mem [FILE_WORDS];  // File registers
  logic [7:0]         wreg_r;                 // Working register
  logic               zero_r;                 // result_null_flag
  logic               carry_r;                // arith_overflow_bit
  logic               sleep_r;                // sleep_flag
  logic               expiry_r;               // expiry_flag
  logic               psa_r;                  // Prescaler assigned to watchdog
  logic               gie_r;                  // global_irq_mask_bit
  logic               skip_r;                 // Last decrement skipped
  logic [WDOG_W-1:0]  wdog_r;                 // watchdog_counter
  logic [PRESC_W-1:0] presc_r;                // shared_prescaler
  mccdo_state_t       state_r;                // Execution state
  logic               ack_r;                  // Bus answer
  logic [31:0]        rdat_r;                 // Read data

  // Bus decode
  wire        bus_req  = WB_CYC_I & WB_STB_I;
  wire        hit_cmd  = (WB_ADR_I == OFS_CMD);
  wire        hit_wreg = (WB_ADR_I == OFS_WREG);
  wire        hit_stat = (WB_ADR_I == OFS_STATUS);
  wire        hit_ctrl = (WB_ADR_I == OFS_CTRL);
  wire        hit_wdog = (WB_ADR_I == OFS_WDOG);
  wire        hit_file = (WB_ADR_I >= OFS_FILE) && (WB_ADR_I[1:0] == 2'b00) &&
                         (WB_ADR_I < OFS_FILE + 10'(FILE_WORDS * 4));
  wire [5:0]  bus_fidx = 6'((WB_ADR_I - OFS_FILE) >> 2);
  wire        busy     = (state_r == ST_NOP);
  // A command is held off while the skip slot runs, so the master waits
  wire        stall    = hit_cmd & WB_WE_I & busy;
  wire        bus_wr   = bus_req & WB_WE_I & ack_r & WB_SEL_I[0];

  // Command fields
  wire [3:0]  op       = WB_DAT_I[CMD_OP_LSB +: CMD_OP_W];
  wire [5:0]  faddr    = WB_DAT_I[CMD_ADDR_LSB +: CMD_ADDR_W];
  wire        dest_f   = WB_DAT_I[CMD_DEST_BIT];
  wire        cmd_fire = bus_wr & hit_cmd;
  wire [7:0]  fval     = file_mem[faddr];

  // Decimal adjust: low digit first, then high digit with carry
  wire        lo_fix   = wreg_r[3:0] > BCD_MAX_DIGIT;
  wire [8:0]  daa_s1   = {1'b0, wreg_r} + (lo_fix ? BCD_LO_FIX : 9'h000);
  wire        hi_fix   = carry_r | daa_s1[8] | (daa_s1[7:4] > BCD_MAX_DIGIT);
  wire [8:0]  daa_s2   = daa_s1 + (hi_fix ? BCD_HI_FIX : 9'h000);

  // Compare difference, carry means no borrow
  wire [8:0]  cmp_d    = {1'b0, fval} - {1'b0, wreg_r};
  wire [7:0]  dec_v    = fval - 8'h01;

  // Result and write-back selection
  logic [7:0] res;
  logic       upd_z;
  logic       upd_c;
  logic       c_val;
  logic       to_w;
  logic       to_f;
  logic       do_skip;
  always_comb begin
    res     = ZERO8;
    upd_z   = 1'b0;
    upd_c   = 1'b0;
    c_val   = 1'b0;
    to_w    = 1'b0;
    to_f    = 1'b0;
    do_skip = 1'b0;
    case (op)
      OP_CLEAR_REG: begin
        // Always back into the file register
        res   = ZERO8;
        upd_z = 1'b1;
        to_f  = 1'b1;
      end
      OP_COMPL_REG: begin
        res   = ~fval;
        upd_z = 1'b1;
        to_w  = ~dest_f;
        to_f  = dest_f;
      end
      OP_COMPARE: begin
        // Difference only feeds the flags
        res   = cmp_d[7:0];
        upd_z = 1'b1;
        upd_c = 1'b1;
        c_val = ~cmp_d[8];
      end
      OP_DEC_ADJ: begin
        res   = daa_s2[7:0];
        upd_c = 1'b1;
        c_val = hi_fix;
        to_w  = 1'b1;
      end
      OP_DEC_SKIP: begin
        res     = dec_v;
        to_w    = ~dest_f;
        to_f    = dest_f;
        do_skip = (dec_v == ZERO8);
      end
      default: begin
        // Remaining codes touch no datapath result
        res = ZERO8;
      end
    endcase
  end

  // Zero flag follows the result wherever an instruction updates it
  wire        z_val    = (res == ZERO8);
  wire        wd_clear = cmd_fire & (op == OP_WDOG_CLEAR);
  wire        presc_wr = &presc_r;

  // Bus answer, one cycle after the request unless stalled
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r & ~stall;
    end
  end

  // Read data mux, captured when the answer is raised
  wire [31:0] rd_stat = {26'h000_0000, skip_r, busy, expiry_r, sleep_r, carry_r, zero_r};
  wire [31:0] rd_mux  = hit_wreg ? {24'h00_0000, wreg_r} :
                        hit_stat ? rd_stat :
                        hit_ctrl ? {30'h0000_0000, gie_r, psa_r} :
                        hit_wdog ? 32'({presc_r, wdog_r}) :
                        hit_file ? {24'h00_0000, file_mem[bus_fidx]} :
                        32'h0000_0000;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rdat_r <= 32'h0000_0000;
    end else if (bus_req & ~ack_r & ~stall) begin
      rdat_r <= rd_mux;
    end
  end

  // File registers: instruction write-back or bus write
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      for (int i = 0; i < FILE_WORDS; i++) begin
        file_mem[i] <= FILE_RST;
      end
    end else if (cmd_fire & to_f) begin
      file_mem[faddr] <= res;
    end else if (bus_wr & hit_file) begin
      file_mem[bus_fidx] <= WB_DAT_I[7:0];
    end
  end

  // Working register
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wreg_r <= WREG_RST;
    end else if (cmd_fire & to_w) begin
      wreg_r <= res;
    end else if (bus_wr & hit_wreg) begin
      wreg_r <= WB_DAT_I[7:0];
    end
  end

  // Arithmetic flags
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      zero_r  <= 1'b0;
      carry_r <= 1'b0;
    end else if (cmd_fire) begin
      if (upd_z) begin
        zero_r <= z_val;
      end
      if (upd_c) begin
        carry_r <= c_val;
      end
    end else if (bus_wr & hit_stat) begin
      zero_r  <= WB_DAT_I[ST_ZERO];
      carry_r <= WB_DAT_I[ST_CARRY];
    end
  end

  // Power flags: watchdog clear sets both, expiry drops on overflow
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sleep_r  <= 1'b1;
      expiry_r <= 1'b1;
    end else if (wd_clear) begin
      sleep_r  <= 1'b1;
      expiry_r <= 1'b1;
    end else if (bus_wr & hit_stat) begin
      sleep_r  <= WB_DAT_I[ST_SLEEP];
      expiry_r <= WB_DAT_I[ST_EXPIRY];
    end else if ((&wdog_r) & (~psa_r | presc_wr)) begin
      expiry_r <= 1'b0;
    end
  end

  // Control bits: prescaler owner and global interrupt mask
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      psa_r <= 1'b0;
      gie_r <= 1'b0;
    end else if (cmd_fire & (op == OP_IRQ_BLOCK)) begin
      gie_r <= 1'b0;
    end else if (cmd_fire & (op == OP_IRQ_UNBLK)) begin
      gie_r <= 1'b1;
    end else if (bus_wr & hit_ctrl) begin
      psa_r <= WB_DAT_I[CT_PSA];
      gie_r <= WB_DAT_I[CT_GIE];
    end
  end

  // Watchdog counter, ticking through the prescaler when assigned
  // The prescaler runs free otherwise; its other owner is outside this block
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      wdog_r  <= '0;
      presc_r <= '0;
    end else if (wd_clear) begin
      wdog_r <= '0;
      if (psa_r) begin
        presc_r <= '0;
      end else begin
        presc_r <= presc_r + 1'b1;
      end
    end else begin
      presc_r <= presc_r + 1'b1;
      if (~psa_r | presc_wr) begin
        wdog_r <= wdog_r + 1'b1;
      end
    end
  end

  // Skip slot: a taken skip spends one more cycle as a no-operation
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_r <= ST_RUN;
      skip_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (cmd_fire & (op == OP_DEC_SKIP)) begin
            skip_r <= do_skip;
            if (do_skip) begin
              state_r <= ST_NOP;
            end
          end
        end
        ST_NOP: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // Outputs
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdat_r;
  assign GIE_OUT  = gie_r;
  assign NOP_SLOT = busy;

  // Checks
  sequence s_fire(logic [3:0] code);
    cmd_fire && op == code;
  endsequence

  a_clear_result: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_CLEAR_REG) |=> file_mem[$past(faddr)] == ZERO8 && zero_r)
    else $error("clear op left register or zero flag wrong");

  a_compl_value: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_COMPL_REG) ##0 dest_f |=> file_mem[$past(faddr)] == ~$past(fval))
    else $error("complement op wrote wrong value");

  a_dest_working: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_COMPL_REG) ##0 !dest_f |=> wreg_r == ~$past(fval)
      && file_mem[$past(faddr)] == $past(fval))
    else $error("target bit zero did not steer into working register");

  a_wdog_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_WDOG_CLEAR) |=> wdog_r == '0 && expiry_r && sleep_r)
    else $error("watchdog clear missed counter or flags");

  a_presc_owner: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_WDOG_CLEAR) ##0 !psa_r |=> presc_r == $past(presc_r) + 1'b1)
    else $error("prescaler disturbed while not owned by watchdog");

  a_compare_keep: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_COMPARE) |=> wreg_r == $past(wreg_r)
      && carry_r == ($past(fval) >= $past(wreg_r)))
    else $error("compare changed operand or carry wrong");

  a_skip_slot: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_DEC_SKIP) ##0 do_skip |=> NOP_SLOT ##1 !NOP_SLOT)
    else $error("skip slot not exactly one cycle");

  a_no_skip: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_DEC_SKIP) ##0 !do_skip |=> !NOP_SLOT)
    else $error("skip taken on nonzero result");

  a_irq_mask: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_IRQ_BLOCK) |=> !GIE_OUT)
    else $error("irq block left mask set");

  a_irq_unmask: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_IRQ_UNBLK) |=> GIE_OUT)
    else $error("irq unblock left mask clear");

  a_compare_file: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_COMPARE) |=> file_mem[$past(faddr)] == $past(fval))
    else $error("compare changed the file register");

  a_compare_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_COMPARE) |=> zero_r == ($past(fval) == $past(wreg_r)))
    else $error("compare zero flag wrong");

  a_dec_value: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_DEC_SKIP) ##0 dest_f |=> file_mem[$past(faddr)] == $past(fval) - 8'h01)
    else $error("decrement wrote wrong value");

  // Only a carry-free adjust is bounded to decimal digits; a stray carry is not
  a_daa_digits: assert property (@(posedge MCLK) disable iff (!RST_N)
    s_fire(OP_DEC_ADJ) ##0 !carry_r |=> wreg_r[3:0] <= BCD_MAX_DIGIT
      && wreg_r[7:4] <= BCD_MAX_DIGIT)
    else $error("decimal adjust left a digit above nine");

  // The bus answer is a single-cycle pulse
  a_ack_pulse: assert property (@(posedge MCLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("bus answer held longer than one cycle");
endmodule : mccdo_core

// ===== verilog/mccdo_pkg.sv
package mccdo_pkg;
  // Register byte offsets on the bus
  localparam logic [9:0] OFS_CMD    = 10'h000;  // Instruction issue, write only
  localparam logic [9:0] OFS_WREG   = 10'h004;  // Working register
  localparam logic [9:0] OFS_STATUS = 10'h008;  // Flags and execution state
  localparam logic [9:0] OFS_CTRL   = 10'h00C;  // Prescaler owner and irq mask
  localparam logic [9:0] OFS_WDOG   = 10'h010;  // Watchdog counter and prescaler
  localparam logic [9:0] OFS_FILE   = 10'h100;  // First file register word
  localparam int         FILE_WORDS = 64;       // File registers 0 to 63
  // Command word fields
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_OP_W     = 4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_ADDR_W   = 6;
  localparam int CMD_DEST_BIT = 16;
  // Status bit positions
  localparam int ST_ZERO   = 0;
  localparam int ST_CARRY  = 1;
  localparam int ST_SLEEP  = 2;
  localparam int ST_EXPIRY = 3;
  localparam int ST_BUSY   = 4;
  localparam int ST_SKIP   = 5;
  // Control bit positions
  localparam int CT_PSA = 0;
  localparam int CT_GIE = 1;
  // Operation codes carried in the command word
  localparam logic [3:0] OP_CLEAR_REG  = 4'h1;  // clear_register_op
  localparam logic [3:0] OP_COMPL_REG  = 4'h2;  // complement_register_op
  localparam logic [3:0] OP_WDOG_CLEAR = 4'h3;  // watchdog_clear_op
  localparam logic [3:0] OP_COMPARE    = 4'h4;  // compare_register_op
  localparam logic [3:0] OP_DEC_ADJ    = 4'h5;  // decimal_adjust_op
  localparam logic [3:0] OP_DEC_SKIP   = 4'h6;  // decrement_skip_zero_op
  localparam logic [3:0] OP_IRQ_BLOCK  = 4'h7;  // irq_block_op
  localparam logic [3:0] OP_IRQ_UNBLK  = 4'h8;  // irq_unblock_op
  // Decimal adjust constants
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [8:0] BCD_LO_FIX    = 9'h006;
  localparam logic [8:0] BCD_HI_FIX    = 9'h060;
  // Reset values
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [7:0] ZERO8    = 8'h00;
  // Execution states, one-hot
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,  // Ready for the next instruction
    ST_NOP = 2'b10   // Discarded slot after a taken skip
  } mccdo_state_t;
endpackage : mccdo_pkg

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  import mccdo_pkg::*;
  logic        mclk;        // Core clock, 100 MHz
  logic        rst_n;       // Sync reset, active low
  logic        cyc, stb, we; // Bus request qualifiers
  logic [9:0]  adr;         // Byte address
  logic [3:0]  sel;         // Byte lanes
  logic [31:0] dat_i;       // Write data
  logic [31:0] dat_o;       // Read data
  logic        ack;         // Bus answer
  logic        global_irq_mask_bit;         // Global irq mask
  logic        nop;         // Discarded slot marker
  logic [31:0] v;           // Scratch read value
  logic [1:0]  ns;          // Skip slot samples
  int          n_mismatch;  // Failed compares
  int          tests_run;   // Compares made

  mccdo_core dut (
    .MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .GIE_OUT(global_irq_mask_bit), .NOP_SLOT(nop)
  );

  // Free running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Single place that prints the verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Classic cycle: hold the request until ack is sampled high, then release
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rdv);
    int i;
    @(posedge mclk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_i <= d;
    sel   <= s;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      chk("ack", 32'h0000_0001, 32'h0000_0000);
      end_sim();
    end
    rdv = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, 4'hF, x);
  endtask : wr

  task automatic rd(input logic [9:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0000_0000, 4'hF, x);
  endtask : rd

  function automatic logic [9:0] fa(input int i);
    return OFS_FILE + 10'(4 * i);
  endfunction : fa

  // Issue one instruction, sample the skip marker in the two following cycles
  task automatic op(input logic [3:0] o, input int r, input logic d);
    logic [31:0] c;
    c = 32'h0000_0000;
    c[3:0] = o;
    c[13:8] = 6'(r);
    c[16] = d;
    wr(OFS_CMD, c);
    #1 ns[0] = nop;
    @(posedge mclk);
    #1 ns[1] = nop;
  endtask : op

  task automatic t_clear;
    wr(fa(63), 32'h0000_0055);
    wr(OFS_STATUS, 32'h0000_0000);
    op(OP_CLEAR_REG, 63, 1'b0);
    rd(fa(63), v); chk("clear file", 32'h0000_0000, v);
    rd(OFS_STATUS, v); chk("clear zero", 32'h0000_0001, v & 32'h1);
  endtask : t_clear

  task automatic t_compl;
    wr(fa(3), 32'h0000_00A6);
    op(OP_COMPL_REG, 3, 1'b1);
    rd(fa(3), v); chk("compl file", 32'h0000_0059, v);
    rd(OFS_STATUS, v); chk("compl zero", 32'h0000_0000, v & 32'h1);
    wr(fa(3), 32'h0000_00FF);
    op(OP_COMPL_REG, 3, 1'b0);
    rd(OFS_WREG, v); chk("compl wreg", 32'h0000_0000, v);
    rd(fa(3), v); chk("compl keep", 32'h0000_00FF, v);
    rd(OFS_STATUS, v); chk("compl zero1", 32'h0000_0001, v & 32'h1);
  endtask : t_compl

  // Smaller, equal and greater working values; carry means no borrow
  task automatic t_compare;
    logic [7:0] w [3];
    logic [1:0] f [3];
    w = '{8'h12, 8'h34, 8'h35};
    f = '{2'b10, 2'b11, 2'b00};
    wr(fa(7), 32'h0000_0034);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_WREG, {24'h0, w[k]});
      wr(OFS_STATUS, 32'h0000_0000);
      op(OP_COMPARE, 7, 1'b0);
      rd(OFS_STATUS, v); chk("cmp flags", {30'h0, f[k]}, v & 32'h3);
      rd(OFS_WREG, v); chk("cmp wreg", {24'h0, w[k]}, v);
      rd(fa(7), v); chk("cmp file", 32'h0000_0034, v);
    end
  endtask : t_compare

  // The decimal adjusted value lands in the working register, irqs blocked around the first adjust only
  task automatic t_daa;
    wr(OFS_STATUS, 32'h0000_0000);
    op(OP_IRQ_BLOCK, 0, 1'b0);
    wr(OFS_WREG, 32'h0000_004D);
    op(OP_DEC_ADJ, 0, 1'b0);
    op(OP_IRQ_UNBLK, 0, 1'b0);
    rd(OFS_WREG, v); chk("daa low", 32'h0000_0053, v);
    rd(OFS_STATUS, v); chk("daa c0", 32'h0000_0000, v & 32'h2);
    wr(OFS_WREG, 32'h0000_009A);
    op(OP_DEC_ADJ, 0, 1'b0);
    rd(OFS_WREG, v); chk("daa wrap", 32'h0000_0000, v);
    rd(OFS_STATUS, v); chk("daa c1", 32'h0000_0002, v & 32'h2);
  endtask : t_daa

  // Prescaler owned by the watchdog, so both counts restart
  // Read comes 3 edges after the clear: prescaler shows 2 when it was zeroed.
  // Not owned, it runs free: 7 edges between the two captures, counter ticks twice.
  task automatic t_wdog;
    logic [31:0] p;
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0000);
    repeat (30) @(posedge mclk);
    op(OP_WDOG_CLEAR, 0, 1'b0);
    rd(OFS_WDOG, v); chk("wdog cnt", 32'h0000_0000, v & 32'hFF);
    chk("wdog presc", 32'h0000_0002, {29'h0, v[10:8]});
    rd(OFS_STATUS, v); chk("wdog flags", 32'h0000_000C, v & 32'hC);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0000);
    rd(OFS_WDOG, p);
    op(OP_WDOG_CLEAR, 0, 1'b0);
    rd(OFS_WDOG, v); chk("wdog cnt free", 32'h0000_0002, v & 32'hFF);
    chk("presc kept", {29'h0, 3'(p[10:8] + 3'd7)}, {29'h0, v[10:8]});
    rd(OFS_STATUS, v); chk("wdog flags2", 32'h0000_000C, v & 32'hC);
  endtask : t_wdog

  task automatic t_dec;
    wr(fa(0), 32'h0000_0002);
    op(OP_DEC_SKIP, 0, 1'b1);
    chk("dec noskip", 32'h0000_0000, {30'h0, ns});
    rd(fa(0), v); chk("dec file", 32'h0000_0001, v);
    rd(OFS_STATUS, v); chk("dec zero0", 32'h0000_0000, v & 32'h1);
    op(OP_DEC_SKIP, 0, 1'b1);
    chk("dec skip", 32'h0000_0001, {30'h0, ns});
    rd(fa(0), v); chk("dec file0", 32'h0000_0000, v);
    // Decrement-and-skip leaves the zero flag alone; only the skip bit rises
    rd(OFS_STATUS, v); chk("dec flags", 32'h0000_0020, v & 32'h21);
    wr(fa(0), 32'h0000_0001);
    op(OP_DEC_SKIP, 0, 1'b0);
    op(OP_DEC_SKIP, 0, 1'b0);
    rd(OFS_WREG, v); chk("dec wreg", 32'h0000_0000, v);
    rd(fa(0), v); chk("dec keep", 32'h0000_0001, v);
  endtask : t_dec

  task automatic t_irq;
    op(OP_IRQ_UNBLK, 0, 1'b0);
    chk("gie on", 32'h0000_0001, {31'h0, global_irq_mask_bit});
    rd(OFS_CTRL, v); chk("ctrl gie", 32'h0000_0002, v & 32'h2);
    op(OP_IRQ_BLOCK, 0, 1'b0);
    chk("gie off", 32'h0000_0000, {31'h0, global_irq_mask_bit});
  endtask : t_irq

  // Lane gating, unmapped and write only places
  task automatic t_misc;
    wr(OFS_WREG, 32'h0000_0011);
    bus(1'b1, OFS_WREG, 32'h0000_0077, 4'hE, v);
    rd(OFS_WREG, v); chk("sel gate", 32'h0000_0011, v);
    wr(10'h0FC, 32'h0000_00AA);
    rd(10'h0FC, v); chk("unmapped", 32'h0000_0000, v);
    rd(OFS_CMD, v); chk("cmd read", 32'h0000_0000, v);
  endtask : t_misc

  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    rst_n = 1'b0;
    {cyc, stb, we} = 3'b000;
    adr   = 10'h000;
    sel   = 4'h0;
    dat_i = 32'h0000_0000;
    ns    = 2'b00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_STATUS, v); chk("rst status", 32'h0000_000C, v);
    chk("rst gie", 32'h0000_0000, {31'h0, global_irq_mask_bit});
    t_clear();
    t_compl();
    t_compare();
    t_daa();
    t_wdog();
    t_dec();
    t_irq();
    t_misc();
    end_sim();
  end
endmodule : tb
